// *** design/crg_regs.svh ***
`ifndef CRG_REGS_SVH
`define CRG_REGS_SVH
// Register byte offsets (AHB word index * 4 since printed offsets are not word aligned)
`define CRG_IDX_FIFO0_CTL 8'hf4
`define CRG_IDX_FIFO1_CTL 8'hf5
`define CRG_ADDR_FIFO0_CTL 12'h3d0
`define CRG_ADDR_FIFO1_CTL 12'h3d4
`define CRG_ADDR_MSTATUS 12'h000
`define CRG_ADDR_DIAG 12'h004
`define CRG_ADDR_BITTIME 12'h008
`define CRG_ADDR_ERRSTAT 12'h00c
`define CRG_ADDR_IRQ_STAT 12'h010
`define CRG_ADDR_IRQ_MASK 12'h014
`define CRG_ADDR_CONFIG 12'h018
// Fields
`define CRG_CTL_COUNT_MASK 8'h03
`define CRG_CTL_RELEASE_BIT 5
`define CRG_MSTATUS_RECV_BIT 5
`define CRG_DIAG_RXPIN_BIT 3
`define CRG_CFG_FIX_BIT 0
`define CRG_CFG_GUARD_BIT 1
// Timing
`define CRG_BTQ_MIN 5'd8
`define CRG_BTQ_MAX 5'd25
`define CRG_RECESSIVE_BITS 4'd8
`define CRG_STORE_BITS 4'd6
`define CRG_BITTIME_RESET 32'h0000_0007
`define CRG_CFG_RESET 32'h0000_0003
`endif

// *** design/crg_pkg.sv ***
package crg_pkg;
  typedef enum logic [1:0] {CRG_IDLE, CRG_FRAME, CRG_TAIL} crg_rx_state_t;
  typedef logic [1:0] crg_ptr_t;
endpackage : crg_pkg

// *** design/crg_fifo_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crg_regs.svh"
module crg_fifo_ctl
  import crg_pkg::*;
#(
  parameter int DEPTH = 3
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fix_en,
  input wire logic store,
  input wire logic release_req,
  output logic [1:0] count,
  output crg_ptr_t rd_ptr,
  output crg_ptr_t wr_ptr,
  output logic fault,
  output logic collide
);
  if (DEPTH != 3)
  begin : g_depth_check
    $error("crg_fifo_ctl: DEPTH must be 3");
  end

  function automatic crg_ptr_t ptr_inc(input crg_ptr_t p);
    ptr_inc = (p == crg_ptr_t'(DEPTH - 1)) ? 2'd0 : p + 2'd1;
  endfunction : ptr_inc

  logic do_rel;
  logic do_store;
  logic hit;
  assign do_rel = release_req && (count != 2'd0);
  assign do_store = store && (count != 2'(DEPTH));
  assign hit = do_rel && store && (count == 2'd2);
  assign collide = hit;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= 2'd0;
    else if (do_store && !do_rel)
      count <= count + 2'd1;
    else if (do_rel && !do_store)
      count <= count - 2'd1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_ptr <= 2'd0;
    else if (do_rel && !(hit && !fix_en))
      rd_ptr <= ptr_inc(rd_ptr);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_ptr <= 2'd0;
    else if (do_store && !fault)
      wr_ptr <= ptr_inc(wr_ptr);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fault <= 1'b0;
    else if (hit && !fix_en)
      fault <= 1'b1;
  end
endmodule : crg_fifo_ctl
`default_nettype wire

// *** design/crg_release_guard.sv ***
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "crg_regs.svh"
module crg_release_guard
  import crg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic can_rx,
  output logic irq
);
  // ------------------------------------------------
  // Pin synchroniser and bit timing
  // ------------------------------------------------
  logic rx_meta_reg;
  logic rx_reg;
  logic rx_prev_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_meta_reg <= 1'b1;
      rx_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= can_rx;
      rx_reg <= rx_meta_reg;
      rx_prev_reg <= rx_reg;
    end
  end

  logic [31:0] bittime_reg;
  logic [31:0] config_reg;
  logic [5:0] prescale;
  logic [4:0] quanta;
  assign prescale = bittime_reg[5:0];
  // quanta per bit clamped to 8..25
  assign quanta = (bittime_reg[12:8] < `CRG_BTQ_MIN) ? `CRG_BTQ_MIN :
                  (bittime_reg[12:8] > `CRG_BTQ_MAX) ? `CRG_BTQ_MAX : bittime_reg[12:8];

  logic [5:0] pre_cnt_reg;
  logic [4:0] tq_cnt_reg;
  logic tq_tick;
  logic bit_tick;
  assign tq_tick = (pre_cnt_reg == prescale);
  assign bit_tick = tq_tick && (tq_cnt_reg == quanta - 5'd1);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_cnt_reg <= 6'd0;
    else if (tq_tick || (rx_prev_reg && !rx_reg))
      pre_cnt_reg <= 6'd0;
    else
      pre_cnt_reg <= pre_cnt_reg + 6'd1;
  end
  // Falling edge resynchronises the bit grid
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tq_cnt_reg <= 5'd0;
    else if (rx_prev_reg && !rx_reg)
      tq_cnt_reg <= 5'd0;
    else if (bit_tick)
      tq_cnt_reg <= 5'd0;
    else if (tq_tick)
      tq_cnt_reg <= tq_cnt_reg + 5'd1;
  end

  // ------------------------------------------------
  // Reception tracker
  // ------------------------------------------------
  crg_rx_state_t state_reg;
  logic [3:0] rec_cnt_reg;
  logic [3:0] tail_cnt_reg;
  logic [1:0] target_reg;
  logic store_pulse;
  logic recv;
  assign recv = (state_reg != CRG_IDLE);
  assign store_pulse = (state_reg == CRG_TAIL) && bit_tick && (tail_cnt_reg == `CRG_STORE_BITS);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= CRG_IDLE;
      rec_cnt_reg <= 4'd0;
      tail_cnt_reg <= 4'd0;
    end
    else
    begin
      case (state_reg)
        CRG_IDLE:
        begin
          if (rx_prev_reg && !rx_reg)
          begin
            state_reg <= CRG_FRAME;
            rec_cnt_reg <= 4'd0;
          end
        end
        CRG_FRAME:
        begin
          if (!rx_reg)
            rec_cnt_reg <= 4'd0;
          else if (bit_tick)
          begin
            rec_cnt_reg <= rec_cnt_reg + 4'd1;
            // recessive beyond five bits means tail
            if (rec_cnt_reg == 4'd5)
            begin
              state_reg <= CRG_TAIL;
              tail_cnt_reg <= 4'd6;
            end
          end
        end
        CRG_TAIL:
        begin
          if (bit_tick)
            tail_cnt_reg <= tail_cnt_reg + 4'd1;
          if (bit_tick && tail_cnt_reg == `CRG_RECESSIVE_BITS - 4'd1)
            state_reg <= CRG_IDLE;
        end
        default:
          state_reg <= CRG_IDLE;
      endcase
    end
  end

  // ------------------------------------------------
  // FIFOs
  // ------------------------------------------------
  logic [1:0] rel_pulse_reg;
  logic [1:0] cnt0;
  logic [1:0] cnt1;
  logic [1:0] fault;
  logic [1:0] coll;
  // Alternate target FIFO per stored frame
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      target_reg <= 2'b01;
    else if (store_pulse)
      target_reg <= {target_reg[0], target_reg[1]};
  end

  crg_fifo_ctl #(.DEPTH(3)) u_fifo0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .fix_en(config_reg[`CRG_CFG_FIX_BIT]),
    .store(store_pulse && target_reg[0]),
    .release_req(rel_pulse_reg[0]),
    .count(cnt0),
    .rd_ptr(),
    .wr_ptr(),
    .fault(fault[0]),
    .collide(coll[0])
  );
  crg_fifo_ctl #(.DEPTH(3)) u_fifo1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .fix_en(config_reg[`CRG_CFG_FIX_BIT]),
    .store(store_pulse && target_reg[1]),
    .release_req(rel_pulse_reg[1]),
    .count(cnt1),
    .rd_ptr(),
    .wr_ptr(),
    .fault(fault[1]),
    .collide(coll[1])
  );

  // ------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------
  logic wr_pend_reg;
  logic [11:0] addr_reg;
  logic [31:0] irq_stat_reg;
  logic [31:0] irq_mask_reg;
  logic [1:0] ev;
  logic acc;
  assign acc = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end
    else
    begin
      wr_pend_reg <= acc && hwrite;
      if (acc)
        addr_reg <= haddr;
    end
  end

  // release bit write gives one-cycle pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rel_pulse_reg <= 2'b00;
    else
    begin
      rel_pulse_reg[0] <= wr_pend_reg && addr_reg == `CRG_ADDR_FIFO0_CTL && hwdata[`CRG_CTL_RELEASE_BIT];
      rel_pulse_reg[1] <= wr_pend_reg && addr_reg == `CRG_ADDR_FIFO1_CTL && hwdata[`CRG_CTL_RELEASE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bittime_reg <= `CRG_BITTIME_RESET;
      config_reg <= `CRG_CFG_RESET;
      irq_mask_reg <= 32'h0000_0000;
    end
    else if (wr_pend_reg)
    begin
      case (addr_reg)
        `CRG_ADDR_BITTIME: bittime_reg <= {19'h0_0000, hwdata[12:8], 2'b00, hwdata[5:0]};
        `CRG_ADDR_CONFIG: config_reg <= {30'h0000_0000, hwdata[1:0]};
        `CRG_ADDR_IRQ_MASK: irq_mask_reg <= {28'h000_0000, hwdata[3:0]};
        default: ;
      endcase
    end
  end

  // Events: bit0 store, bit1 collision, bit2 frame end, bit3 fault
  logic recv_prev_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      recv_prev_reg <= 1'b0;
    else
      recv_prev_reg <= recv;
  end
  assign ev = {recv_prev_reg && !recv, |coll};
  // Set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_reg <= 32'h0000_0000;
    else
    begin
      if (wr_pend_reg && addr_reg == `CRG_ADDR_IRQ_STAT)
        irq_stat_reg <= irq_stat_reg & ~{28'h000_0000, hwdata[3:0]}
                        | {28'h000_0000, |fault, ev, store_pulse};
      else
        irq_stat_reg <= irq_stat_reg | {28'h000_0000, |fault, ev, store_pulse};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_mask_reg);
  end

  // Guard: MSTATUS flag while critical slot possible, release itself not blocked
  logic guard_busy;
  assign guard_busy = recv && rx_reg;

  // Decoded at the address phase: no wait state, data still leaves a flop
  // Limitation: a read right behind a write to the same register sees the old value
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      `CRG_ADDR_FIFO0_CTL: rd_mux = {30'h0000_0000, cnt0};
      `CRG_ADDR_FIFO1_CTL: rd_mux = {30'h0000_0000, cnt1};
      `CRG_ADDR_MSTATUS: rd_mux = {26'h000_0000, recv, 1'b0, guard_busy, 1'b0, fault};
      `CRG_ADDR_DIAG: rd_mux = {28'h000_0000, rx_reg, 3'b000};
      `CRG_ADDR_BITTIME: rd_mux = bittime_reg;
      `CRG_ADDR_CONFIG: rd_mux = config_reg;
      `CRG_ADDR_IRQ_STAT: rd_mux = irq_stat_reg;
      `CRG_ADDR_IRQ_MASK: rd_mux = irq_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (acc && !hwrite)
      hrdata <= rd_mux;
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule : crg_release_guard
`default_nettype wire

// *** bench/crg_release_guard_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crg_regs.svh"
module crg_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic can_rx
);
  wire logic rd_acc = hsel & htrans[1] & hready & !hwrite;
  logic rd_q, rx_q, pin_q, calm_q, idle_q;
  logic [2:0] stab;
  logic [11:0] ra_q, idle_cnt;
  // ----
  // Pin history per address phase
  // ----
  always_ff @(posedge hclk)
  begin
    ra_q <= haddr;
    pin_q <= can_rx;
    calm_q <= stab > 3'h3;
    idle_q <= idle_cnt > 12'h7d0;
  end
  // Synchroniser delay: pin trusted only once steady
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd_q <= 1'b0;
      rx_q <= 1'b1;
      stab <= 3'h0;
      idle_cnt <= 12'h0;
    end
    else
    begin
      rd_q <= rd_acc;
      rx_q <= can_rx;
      stab <= (can_rx != rx_q) ? 3'h0 : stab + {2'h0, stab != 3'h7};
      idle_cnt <= !can_rx ? 12'h0 : idle_cnt + {11'h0, idle_cnt != 12'hfff};
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout) else $error("ready low");
  a_resp_okay: assert property (!hresp) else $error("bad response");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_acc))
    else $error("read data moved");
  a_diag_pin: assert property (rd_q && ra_q == `CRG_ADDR_DIAG && calm_q |-> hrdata[3] == pin_q)
    else $error("pin bit wrong");
  a_unmapped_zero: assert property (rd_q && ra_q[11:5] == 7'h01 |-> hrdata == 32'h0)
    else $error("unmapped nonzero");
  a_idle_quiet: assert property (rd_q && ra_q == `CRG_ADDR_MSTATUS && idle_q |-> !hrdata[5])
    else $error("receiving while idle");
  a_guard_recv: assert property (rd_q && ra_q == `CRG_ADDR_MSTATUS && hrdata[3] |-> hrdata[5])
    else $error("guard without reception");
  a_dominant_free: assert property (rd_q && ra_q == `CRG_ADDR_MSTATUS && calm_q && !pin_q |-> !hrdata[3])
    else $error("guard on dominant");
endmodule : crg_chk
bind crg_release_guard crg_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .can_rx);
`default_nettype wire

// *** bench/crg_can_node.sv ***
`timescale 1ns/1ps
`default_nettype none
module crg_can_node #(
  parameter int BIT_CLKS = 8
)
(
  input wire logic hclk,
  output logic can_rx,
  output logic ack_end
);
  initial
  begin
    can_rx = 1'b1;
    ack_end = 1'b0;
  end
  task automatic put(input logic b);
    can_rx <= b;
    repeat (BIT_CLKS) @(posedge hclk);
  endtask : put
  // ----
  // Frame sender
  // ----
  task automatic send_frame(input logic [31:0] d, input int n);
    int run;
    logic last;
    run = 1;
    last = 1'b0;
    put(1'b0);
    for (int i = 0; i < n; i++)
    begin
      put(d[i]);
      run = (d[i] == last) ? run + 1 : 1;
      last = d[i];
      if (run == 5)
      begin
        put(!last);
        last = !last;
        run = 1;
      end
    end
    put(1'b1);
    put(1'b0);
    // Bus idles recessive, as the pull-up leaves it
    can_rx <= 1'b1;
    ack_end <= 1'b1;
    @(posedge hclk);
    ack_end <= 1'b0;
    repeat (28 * BIT_CLKS) @(posedge hclk);
  endtask : send_frame
endmodule : crg_can_node
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crg_regs.svh"
module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tgt = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [1:0] v;
  logic [11:0] haddr = 12'h0;
  logic [31:0] hwdata = 32'h0, lfsr = 32'h0000_dd95, hrdata, rd;
  logic hreadyout, hresp, can_rx, irq, ack_end;
  int bad_count = 0, checked = 0;
  always #25 hclk = ~hclk;
  crg_release_guard uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .can_rx, .irq);
  crg_can_node #(.BIT_CLKS(8)) node (.hclk, .can_rx, .ack_end);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [11:0] fa(input logic t);
    return t ? `CRG_ADDR_FIFO1_CTL : `CRG_ADDR_FIFO0_CTL;
  endfunction : fa
  function automatic logic [31:0] flt(input logic fix, input logic t);
    return fix ? 32'h0 : {30'h0, t, !t};
  endfunction : flt
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdc
  // count test runs straight into the release unless two frames are held, then the guard is polled first
  task automatic safe_release(input logic t);
    bus(1'b0, fa(t), 32'h0);
    if (rd[1:0] == 2'h2)
    begin
      // each poll lasts three clocks, well inside one bit
      do
        bus(1'b0, `CRG_ADDR_MSTATUS, 32'h0);
      while (rd[5] && rd[3]);
    end
    bus(1'b1, fa(t), 32'h0000_0020);
  endtask : safe_release
  task automatic frame();
    lfsr = nxt(lfsr);
    node.send_frame(lfsr, 16 + lfsr[3:0]);
  endtask : frame
  task automatic irq_pair();
    bus(1'b1, `CRG_ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    v[0] = irq;
    bus(1'b1, `CRG_ADDR_IRQ_MASK, 32'h0000_000f);
    repeat (2) @(posedge hclk);
    v[1] = irq;
  endtask : irq_pair
  task automatic sweep(input logic fix);
    logic hit;
    hit = 1'b0;
    bus(1'b1, `CRG_ADDR_CONFIG, {31'h0, fix});
    // Slide the release over the store slot until they meet
    for (int off = 20; off < 200 && !hit; off++)
    begin
      fork
        frame();
        begin
          @(posedge ack_end);
          repeat (off) @(posedge hclk);
          bus(1'b1, fa(tgt), 32'h0000_0020);
        end
      join
      bus(1'b0, `CRG_ADDR_IRQ_STAT, 32'h0);
      hit = rd[1];
      bus(1'b1, `CRG_ADDR_IRQ_STAT, 32'h0000_000f);
      rdc(fa(tgt), 32'h2, 32'h3);
      tgt = !tgt;
    end
    chk({31'h0, hit}, 32'h1);
    rdc(`CRG_ADDR_MSTATUS, flt(fix, !tgt), 32'h3);
  endtask : sweep
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`CRG_ADDR_BITTIME, `CRG_BITTIME_RESET, 32'hffff_ffff);
    rdc(`CRG_ADDR_CONFIG, `CRG_CFG_RESET, 32'hffff_ffff);
    rdc(`CRG_ADDR_DIAG, 32'h8, 32'h8);
    rdc(12'h020, 32'h0, 32'hffff_ffff);
    bus(1'b1, `CRG_ADDR_BITTIME, 32'h0000_0800);
    rdc(`CRG_ADDR_BITTIME, 32'h0000_0800, 32'h0000_1f3f);
    repeat (4)
    begin
      fork
        frame();
        begin
          repeat (40) @(posedge hclk);
          rdc(`CRG_ADDR_MSTATUS, 32'h20, 32'h20);
          bus(1'b0, `CRG_ADDR_DIAG, 32'h0);
        end
      join
      rdc(`CRG_ADDR_MSTATUS, 32'h0, 32'h20);
    end
    // Long recessive stretch, reception must be over
    repeat (1900) @(posedge hclk);
    rdc(`CRG_ADDR_MSTATUS, 32'h0, 32'h20);
    rdc(`CRG_ADDR_FIFO0_CTL, 32'h2, 32'h3);
    rdc(`CRG_ADDR_FIFO1_CTL, 32'h2, 32'h3);
    rdc(`CRG_ADDR_IRQ_STAT, 32'h1, 32'h1);
    irq_pair();
    chk({31'h0, v[0] ^ v[1]}, 32'h1);
    bus(1'b1, `CRG_ADDR_IRQ_STAT, 32'h0000_000f);
    rdc(`CRG_ADDR_IRQ_STAT, 32'h0, 32'h7);
    irq_pair();
    chk({30'h0, v}, 32'h0);
    bus(1'b1, `CRG_ADDR_FIFO0_CTL, 32'h0000_0020);
    rdc(`CRG_ADDR_FIFO0_CTL, 32'h1, 32'h3);
    frame();
    rdc(`CRG_ADDR_FIFO0_CTL, 32'h2, 32'h3);
    sweep(1'b1);
    sweep(1'b0);
    fork
      frame();
      begin
        @(posedge ack_end);
        repeat (20) @(posedge hclk);
        safe_release(tgt);
      end
    join
    rdc(fa(tgt), 32'h2, 32'h3);
    rdc(`CRG_ADDR_MSTATUS, flt(1'b0, !tgt), 32'h3);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`CRG_ADDR_MSTATUS, 32'h0, 32'h3);
    print_verdict();
  end
  initial
  begin
    #4000000;
    bad_count++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
